// file: src/gpb_port.sv
// Eight-pin port: registers, atomic output update, interrupt flags, wake-up
`timescale 1ns/1ps
`default_nettype none
module gpb_port
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [gpb_pkg::ADDR_W-1:0] addr_in,
  input wire logic [gpb_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [gpb_pkg::DATA_W-1:0] rd_data_out,
  input wire logic [gpb_pkg::NPIN-1:0] pin_in_in,
  output logic [gpb_pkg::NPIN-1:0] pin_out_out,
  output logic [gpb_pkg::NPIN-1:0] pin_oe_out,
  output logic [gpb_pkg::NPIN-1:0] pull_up_out,
  output logic [gpb_pkg::NPIN-1:0] pull_dn_out,
  output logic [gpb_pkg::NPIN-1:0] in_buf_en_out,
  input wire logic [gpb_pkg::NPIN*gpb_pkg::NAF-1:0] af_data_in,
  output logic [gpb_pkg::NPIN*gpb_pkg::NAF-1:0] periph_in_out,
  input wire logic fast_osc_enable_in,
  input wire logic fast_osc_bypass_in,
  input wire logic fast_osc_pin_analog_in,
  input wire logic slow_osc_enable_in,
  input wire logic slow_osc_bypass_in,
  input wire logic slow_osc_pin_analog_in,
  input wire logic sleep_mode_in,
  output logic wakeup_req_out,
  output logic irq_out
);
  import gpb_pkg::*;

  logic [NPIN-1:0] dir_q;
  logic [NPIN-1:0] otype_q;
  logic [NPIN-1:0] odr_q;
  logic [NPIN-1:0] inten_q;
  logic [NPIN-1:0] inttyp_q;
  logic [NPIN-1:0] intpol_q;
  logic [2*NPIN-1:0] pupd_q;
  logic [NPIN*AFW-1:0] afr_q;
  logic [NPIN-1:0] status_q;
  logic [NPIN-1:0] status_d;
  logic [DATA_W-1:0] rd_d;
  logic [NPIN-1:0] wd;
  logic [NPIN-1:0] clr_mask;
  logic [NPIN-1:0] sync_vec;
  logic [NPIN-1:0] idr_vec;
  logic [NPIN-1:0] dig_vec;
  logic [NPIN-1:0] evt_vec;
  logic [NPIN-1:0] osc_own;
  logic [NPIN-1:0] osc_ana;

  assign wd = wr_data_in[NPIN-1:0];

  // Pins are asynchronous, so every level passes two flops first
  gpb_sync u_sync
  (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(pin_in_in),
    .sync_out(sync_vec)
  );

  // Oscillator pin ownership
  always_comb
  begin
    osc_own = '0;
    osc_ana = '0;
    osc_own[FOSC_IN] = fast_osc_enable_in;
    // In bypass only the input pin carries the clock
    osc_own[FOSC_OUT] = fast_osc_enable_in & ~fast_osc_bypass_in;
    osc_own[SOSC_IN] = slow_osc_enable_in;
    osc_own[SOSC_OUT] = slow_osc_enable_in & ~slow_osc_bypass_in;
    osc_ana[FOSC_IN] = fast_osc_pin_analog_in;
    osc_ana[FOSC_OUT] = fast_osc_pin_analog_in & ~fast_osc_bypass_in;
    osc_ana[SOSC_IN] = slow_osc_pin_analog_in;
    osc_ana[SOSC_OUT] = slow_osc_pin_analog_in & ~slow_osc_bypass_in;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      gpb_pin u_pin
      (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .dir_in(dir_q[gi]),
        .otype_in(otype_q[gi]),
        .odr_in(odr_q[gi]),
        .afr_in(afr_q[gi*AFW +: AFW]),
        .pupd_in(pupd_q[2*gi +: 2]),
        .af_data_in(af_data_in[gi*NAF +: NAF]),
        .osc_own_in(osc_own[gi]),
        .osc_analog_in(osc_ana[gi]),
        .sync_in(sync_vec[gi]),
        .int_type_in(inttyp_q[gi]),
        .int_pol_in(intpol_q[gi]),
        .pin_out_out(pin_out_out[gi]),
        .pin_oe_out(pin_oe_out[gi]),
        .pull_up_out(pull_up_out[gi]),
        .pull_dn_out(pull_dn_out[gi]),
        .in_buf_en_out(in_buf_en_out[gi]),
        .idr_out(idr_vec[gi]),
        .digital_out(dig_vec[gi]),
        .periph_in_out(periph_in_out[gi*NAF +: NAF]),
        .int_evt_out(evt_vec[gi])
      );
    end
  endgenerate

  // Output data: direct, set and clear writes in one cycle
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      odr_q <= '0;
    else if (wr_en_in)
    begin
      case (addr_in)
        OFS_ODR: odr_q <= wd;
        OFS_ODSET: odr_q <= odr_q | wd;
        OFS_ODCLR: odr_q <= odr_q & ~wd;
        default: odr_q <= odr_q;
      endcase
    end
  end

  // Pin configuration
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      dir_q <= DIR_RST;
      otype_q <= '0;
      pupd_q <= PUPD_RST;
      afr_q <= AFR_RST;
    end
    else if (wr_en_in)
    begin
      case (addr_in)
        OFS_DIR: dir_q <= wd;
        OFS_OTYPE: otype_q <= wd;
        OFS_PUPD: pupd_q <= wr_data_in[2*NPIN-1:0];
        OFS_AFR: afr_q <= wr_data_in[NPIN*AFW-1:0];
        default: dir_q <= dir_q;
      endcase
    end
  end

  // Interrupt configuration
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      inten_q <= '0;
      inttyp_q <= '0;
      intpol_q <= '0;
    end
    else if (wr_en_in)
    begin
      case (addr_in)
        OFS_INTEN: inten_q <= wd;
        OFS_INTTYP: inttyp_q <= wd;
        OFS_INTPOL: intpol_q <= wd;
        default: inten_q <= inten_q;
      endcase
    end
  end

  // Raw flags latch even when masked; a new event wins over a clear
  assign clr_mask = (wr_en_in && addr_in == OFS_INTCLR) ? wd : '0;
  assign status_d = (status_q & ~clr_mask) | evt_vec;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      status_q <= '0;
    else
      status_q <= status_d;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(status_d & inten_q);
  end

  // Held until the chip leaves sleep
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      wakeup_req_out <= 1'b0;
    else if (!sleep_mode_in)
      wakeup_req_out <= 1'b0;
    else if (|(evt_vec & inten_q))
      wakeup_req_out <= 1'b1;
  end

  // Read mux; unmapped and write-only offsets read zero
  always_comb
  begin
    rd_d = '0;
    case (addr_in)
      OFS_DIR: rd_d[NPIN-1:0] = dir_q;
      OFS_OTYPE: rd_d[NPIN-1:0] = otype_q;
      OFS_ODR: rd_d[NPIN-1:0] = odr_q;
      OFS_IDR: rd_d[NPIN-1:0] = idr_vec;
      OFS_INTEN: rd_d[NPIN-1:0] = inten_q;
      OFS_RAWST: rd_d[NPIN-1:0] = status_q;
      OFS_MSKST: rd_d[NPIN-1:0] = status_q & inten_q;
      OFS_INTTYP: rd_d[NPIN-1:0] = inttyp_q;
      OFS_INTPOL: rd_d[NPIN-1:0] = intpol_q;
      OFS_PUPD: rd_d[2*NPIN-1:0] = pupd_q;
      OFS_AFR: rd_d[NPIN*AFW-1:0] = afr_q;
      OFS_ODSET: rd_d = '0;
      OFS_ODCLR: rd_d = '0;
      default: rd_d = '0;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      rd_data_out <= '0;
    else if (rd_en_in)
      rd_data_out <= rd_d;
    else
      rd_data_out <= '0;
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_set_wr;
    wr_en_in && addr_in == OFS_ODSET;
  endsequence

  sequence s_clr_wr;
    wr_en_in && addr_in == OFS_ODCLR;
  endsequence

  chk_set_bits: assert property (s_set_wr |=>
    odr_q == ($past(odr_q) | $past(wd)))
    else $error("set write wrong");
  chk_clr_bits: assert property (s_clr_wr |=>
    odr_q == ($past(odr_q) & ~$past(wd)))
    else $error("clear write wrong");
  chk_odr_write: assert property ((wr_en_in && addr_in == OFS_ODR) |=>
    odr_q == $past(wd))
    else $error("direct write lost");
  chk_odr_read: assert property ((rd_en_in && addr_in == OFS_ODR) |=>
    rd_data_out[NPIN-1:0] == $past(odr_q))
    else $error("output data read wrong");
  chk_setclr_rd0: assert property
    ((rd_en_in && (addr_in == OFS_ODSET || addr_in == OFS_ODCLR)) |=> rd_data_out == '0)
    else $error("set or clear reads nonzero");
  chk_idr_sync: assert property ($past(rst_n_in, 2) |->
    idr_vec == ($past(pin_in_in, 2) & dig_vec))
    else $error("input sample wrong");
  chk_status_hold: assert property (!(wr_en_in && addr_in == OFS_INTCLR) |=>
    (status_q & $past(status_q)) == $past(status_q))
    else $error("status flag lost");
  chk_status_clr: assert property ((wr_en_in && addr_in == OFS_INTCLR) |=>
    (status_q & $past(wd) & ~$past(evt_vec)) == '0)
    else $error("status not cleared");
  chk_flag_set: assert property (|evt_vec |=> (status_q & $past(evt_vec)) == $past(evt_vec))
    else $error("event not recorded");
  chk_wake_req: assert property ((sleep_mode_in && |(evt_vec & inten_q)) |=>
    wakeup_req_out)
    else $error("wake-up missing");
  chk_byp_out_free: assert property
    ((fast_osc_enable_in && fast_osc_bypass_in) |-> !osc_own[FOSC_OUT] && osc_own[FOSC_IN])
    else $error("bypass pin held");
  // Reset itself is the antecedent, so the default disable must not apply here
  chk_dir_reset: assert property (@(posedge core_clk_in) disable iff (1'b0)
    !rst_n_in |=> (dir_q == DIR_RST && afr_q == AFR_RST))
    else $error("reset value wrong");

  // Read data fall back to zero so a stale word is never mistaken for an answer
  chk_rd_idle: assert property (!rd_en_in |=> rd_data_out == '0)
    else $error("read data not cleared");
  chk_idr_read: assert property ((rd_en_in && addr_in == OFS_IDR) |=>
    rd_data_out[NPIN-1:0] == $past(idr_vec))
    else $error("input data read wrong");
  chk_raw_read: assert property ((rd_en_in && addr_in == OFS_RAWST) |=>
    rd_data_out[NPIN-1:0] == $past(status_q))
    else $error("status read wrong");
  chk_msk_read: assert property ((rd_en_in && addr_in == OFS_MSKST) |=>
    rd_data_out[NPIN-1:0] == ($past(status_q) & $past(inten_q)))
    else $error("masked status read wrong");
  chk_wake_drop: assert property (!sleep_mode_in |=> !wakeup_req_out)
    else $error("wake-up held while awake");
  chk_irq_quiet: assert property (((status_q & inten_q) == '0 && evt_vec == '0) |=>
    !irq_out)
    else $error("interrupt without flag");
  chk_set_zero: assert property ((wr_en_in && addr_in == OFS_ODSET && wd == '0) |=>
    odr_q == $past(odr_q))
    else $error("zero set changed output");
  chk_clr_zero: assert property ((wr_en_in && addr_in == OFS_ODCLR && wd == '0) |=>
    odr_q == $past(odr_q))
    else $error("zero clear changed output");
  chk_dir_write: assert property ((wr_en_in && addr_in == OFS_DIR) |=>
    dir_q == $past(wd))
    else $error("direction write lost");
  chk_fast_own: assert property (fast_osc_enable_in |-> osc_own[FOSC_IN])
    else $error("fast oscillator pin not owned");
  chk_slow_byp: assert property
    ((slow_osc_enable_in && slow_osc_bypass_in) |-> !osc_own[SOSC_OUT] && osc_own[SOSC_IN])
    else $error("slow bypass pin held");
endmodule
`default_nettype wire

// file: src/gpb_pkg.sv
// Shared constants and types of the eight-pin port
package gpb_pkg;
  localparam int NPIN = 8;
  localparam int AFW = 4;
  localparam int NAF = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_DIR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OTYPE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ODR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IDR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_INTEN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RAWST = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MSKST = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_INTCLR = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_INTTYP = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_INTPOL = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_ODSET = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_ODCLR = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_PUPD = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_AFR = 8'h48;
  localparam logic [AFW-1:0] AF_GPIO = 4'h0;
  localparam logic [AFW-1:0] AF_ANALOG = 4'hF;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DN = 2'h2;
  localparam logic [NPIN-1:0] DIR_RST = 8'h00;
  localparam logic [NPIN*AFW-1:0] AFR_RST = 32'h1000_0000;
  localparam logic [2*NPIN-1:0] PUPD_RST = 16'h4000;
  localparam int FOSC_IN = 1;
  localparam int FOSC_OUT = 2;
  localparam int SOSC_IN = 5;
  localparam int SOSC_OUT = 4;
  typedef enum logic [2:0] {MODE_IN, MODE_OUT, MODE_AF, MODE_ANALOG, MODE_OSC} gpb_mode_e;
endpackage

// file: src/gpb_sync.sv
// Two-stage synchroniser for the pin levels
`timescale 1ns/1ps
`default_nettype none
module gpb_sync
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [gpb_pkg::NPIN-1:0] async_in,
  output logic [gpb_pkg::NPIN-1:0] sync_out
);
  import gpb_pkg::*;
  logic [NPIN-1:0] meta_q;

  // The first stage feeds only the second stage
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: src/gpb_pin.sv
// One pin slice: mode, driver, pulls, function mux and trigger detect
`timescale 1ns/1ps
`default_nettype none
module gpb_pin
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic dir_in,
  input wire logic otype_in,
  input wire logic odr_in,
  input wire logic [gpb_pkg::AFW-1:0] afr_in,
  input wire logic [1:0] pupd_in,
  input wire logic [gpb_pkg::NAF-1:0] af_data_in,
  input wire logic osc_own_in,
  input wire logic osc_analog_in,
  input wire logic sync_in,
  input wire logic int_type_in,
  input wire logic int_pol_in,
  output logic pin_out_out,
  output logic pin_oe_out,
  output logic pull_up_out,
  output logic pull_dn_out,
  output logic in_buf_en_out,
  output logic idr_out,
  output logic digital_out,
  output logic [gpb_pkg::NAF-1:0] periph_in_out,
  output logic int_evt_out
);
  import gpb_pkg::*;
  gpb_mode_e mode;
  logic drv_d;
  logic prev_q;
  logic rise;
  logic fall;

  // Oscillator ownership overrides any port setting
  always_comb
  begin
    if (osc_own_in)
      mode = MODE_OSC;
    else if (afr_in == AF_ANALOG || osc_analog_in)
      mode = MODE_ANALOG;
    else if (afr_in != AF_GPIO)
      mode = MODE_AF;
    else if (dir_in)
      mode = MODE_OUT;
    else
      mode = MODE_IN;
  end

  assign digital_out = (mode == MODE_IN) || (mode == MODE_OUT) || (mode == MODE_AF);
  // Analog and oscillator pins read as zero
  assign idr_out = sync_in & digital_out;

  always_comb
  begin
    drv_d = odr_in;
    if (mode == MODE_AF)
      drv_d = af_data_in[afr_in];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      pin_out_out <= 1'b0;
      pin_oe_out <= 1'b0;
      pull_up_out <= 1'b0;
      pull_dn_out <= 1'b0;
      in_buf_en_out <= 1'b0;
    end
    else
    begin
      // Open drain never drives high, so the high level is released
      pin_out_out <= drv_d & ~otype_in;
      pin_oe_out <= (mode == MODE_OUT || mode == MODE_AF) && !(otype_in && drv_d);
      pull_up_out <= digital_out && (pupd_in == PULL_UP);
      pull_dn_out <= digital_out && (pupd_in == PULL_DN);
      in_buf_en_out <= digital_out;
    end
  end

  assign periph_in_out = (mode == MODE_AF) ? (NAF'(sync_in) << afr_in) : '0;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      prev_q <= 1'b0;
    else
      prev_q <= idr_out;
  end

  assign rise = idr_out & ~prev_q;
  assign fall = ~idr_out & prev_q;
  assign int_evt_out = digital_out &
    (int_type_in ? (int_pol_in ? rise : fall) : (int_pol_in ? idr_out : ~idr_out));

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rise;
    !idr_out ##1 (idr_out && int_type_in && int_pol_in && digital_out);
  endsequence

  chk_input_drv_off: assert property (mode == MODE_IN |=> !pin_oe_out)
    else $error("input pin driven");
  chk_od_no_high: assert property ((mode == MODE_OUT && otype_in) |=>
    (!pin_out_out && pin_oe_out == !$past(odr_in)))
    else $error("open drain drive wrong");
  chk_pp_drive: assert property ((mode == MODE_OUT && !otype_in) |=>
    (pin_oe_out && pin_out_out == $past(odr_in)))
    else $error("push pull drive wrong");
  chk_af_drive: assert property ((mode == MODE_AF && !otype_in) |=>
    (pin_oe_out && pin_out_out == $past(drv_d)))
    else $error("function output wrong");
  chk_analog_off: assert property (mode == MODE_ANALOG |=>
    !(pin_oe_out || pull_up_out || pull_dn_out || in_buf_en_out))
    else $error("analog pin not isolated");
  chk_pull_follow: assert property (mode == MODE_IN |=>
    (pull_up_out == ($past(pupd_in) == PULL_UP)))
    else $error("pull enable wrong");
  chk_rise_flag: assert property (s_rise |-> int_evt_out)
    else $error("rising edge missed");
  chk_osc_owned: assert property (osc_own_in |=> !pin_oe_out && !pull_up_out)
    else $error("oscillator pin driven");
endmodule
`default_nettype wire

// file: verif/gpb_pad_model.sv
// Pad model: resolves each pin level from driver, pulls and an outside source
`timescale 1ns/1ps
`default_nettype none
module gpb_pad_model
(
  input wire logic core_clk_in,
  input wire logic [gpb_pkg::NPIN-1:0] pin_out_in,
  input wire logic [gpb_pkg::NPIN-1:0] pin_oe_in,
  input wire logic [gpb_pkg::NPIN-1:0] pull_up_in,
  input wire logic [gpb_pkg::NPIN-1:0] pull_dn_in,
  input wire logic [gpb_pkg::NPIN-1:0] ext_en_in,
  input wire logic [gpb_pkg::NPIN-1:0] ext_val_in,
  output logic [gpb_pkg::NPIN-1:0] pin_level_out
);
  import gpb_pkg::*;
  logic [NPIN-1:0] float_q = 8'h00;
  // A floating pad wanders, so nothing may lean on its last value
  always_ff @(posedge core_clk_in)
  begin
    float_q <= ~float_q;
  end
  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      if (pin_oe_in[i]) pin_level_out[i] = pin_out_in[i];
      else if (ext_en_in[i]) pin_level_out[i] = ext_val_in[i];
      else if (pull_up_in[i]) pin_level_out[i] = 1'b1;
      else if (pull_dn_in[i]) pin_level_out[i] = 1'b0;
      else pin_level_out[i] = float_q[i];
    end
  end
endmodule
`default_nettype wire

// file: verif/gpio_port_bit_logic_tb.sv
// Self-checking bench for the eight-pin port
`timescale 1ns/1ps
`default_nettype none
module gpio_port_bit_logic_tb;
  import gpb_pkg::*;
  logic clk, rst_n, wr_en, rd_en, sleep, wake, irq;
  logic [7:0] addr, pin_in, pin_out, pin_oe, pu, pd, ibe, ext_en, ext_val, odr;
  logic [31:0] wdata, rdata, v;
  logic [127:0] af_data, periph;
  logic [5:0] osc;
  logic [15:0] cfg;
  int n_fail = 0;
  int comparisons = 0;

  gpb_port gpb_port_inst (.core_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
    .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
    .pin_in_in(pin_in), .pin_out_out(pin_out), .pin_oe_out(pin_oe), .pull_up_out(pu),
    .pull_dn_out(pd), .in_buf_en_out(ibe), .af_data_in(af_data), .periph_in_out(periph),
    .fast_osc_enable_in(osc[0]), .fast_osc_bypass_in(osc[1]),
    .fast_osc_pin_analog_in(osc[2]), .slow_osc_enable_in(osc[3]),
    .slow_osc_bypass_in(osc[4]), .slow_osc_pin_analog_in(osc[5]),
    .sleep_mode_in(sleep), .wakeup_req_out(wake), .irq_out(irq));
  gpb_pad_model gpb_pad_model_inst (.core_clk_in(clk), .pin_out_in(pin_out),
    .pin_oe_in(pin_oe), .pull_up_in(pu), .pull_dn_in(pd), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .pin_level_out(pin_in));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    // Read data stand only in the cycle after the strobe is taken
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [7:0] odr_next(input int op, input logic [7:0] o, input logic [7:0] m);
    if (op == 0) return m;
    if (op == 1) return o | m;
    return o & ~m;
  endfunction
  function automatic logic [15:0] pull_exp(input logic [15:0] c);
    for (int i = 0; i < NPIN; i++)
    begin
      pull_exp[i] = (c[2*i+:2] == PULL_UP);
      pull_exp[8+i] = (c[2*i+:2] == PULL_DN);
    end
  endfunction

  initial
  begin
    #(40 * 20000);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    rst_n = 1'b0;
    {wr_en, rd_en, sleep} = 3'h0;
    {addr, wdata, af_data, osc, ext_en, ext_val} = '0;
    void'($urandom(32'h1D68C822));
    idle(10);
    rst_n <= 1'b1;
    idle(2);
    rchk(OFS_DIR, 32'h0);
    rchk(OFS_AFR, AFR_RST);
    rchk(OFS_PUPD, {16'h0, PUPD_RST});
    // The debug pin comes up in its function, which drives the pad
    chk({pu, pin_oe}, 16'h8080);
    wr(OFS_AFR, 32'h0);
    odr = 8'h00;
    repeat (24)
    begin
      int op;
      v = $urandom;
      op = $urandom_range(2, 0);
      wr((op == 0) ? OFS_ODR : (op == 1) ? OFS_ODSET : OFS_ODCLR, v);
      odr = odr_next(op, odr, v[7:0]);
      rchk(OFS_ODR, {24'h0, odr});
    end
    rchk(OFS_ODSET, 32'h0);
    rchk(OFS_ODCLR, 32'h0);
    ext_en <= 8'hFF;
    ext_val <= ~odr;
    idle(4);
    chk(pin_oe, 8'h00);
    rchk(OFS_ODR, {24'h0, odr});
    repeat (4)
    begin
      v = $urandom;
      ext_val <= v[7:0];
      idle(4);
      rchk(OFS_IDR, {24'h0, v[7:0]});
    end
    ext_en <= 8'h00;
    wr(OFS_DIR, 32'hFF);
    idle(3);
    chk({pin_oe, pin_out}, {8'hFF, odr});
    wr(OFS_OTYPE, 32'hFF);
    idle(3);
    chk({pin_oe, pin_out}, {~odr, 8'h00});
    wr(OFS_OTYPE, 32'h0);
    repeat (4)
    begin
      for (int i = 0; i < NPIN; i++) cfg[2*i+:2] = 2'($urandom_range(2, 0));
      wr(OFS_PUPD, {16'h0, cfg});
      idle(3);
      chk({pd, pu}, pull_exp(cfg));
    end
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    wr(OFS_PUPD, 32'h5555);
    wr(OFS_AFR, 32'hFFFF_FFFF);
    idle(4);
    chk({pin_oe, ibe, pu, pd}, 32'h0);
    rchk(OFS_IDR, 32'h0);
    // Pin 0 on function 3; its pull-up holds the pad when open drain releases it
    wr(OFS_PUPD, 32'h1);
    wr(OFS_AFR, 32'h3);
    ext_en <= 8'hFE;
    for (int t = 0; t < 4; t++)
    begin
      af_data[3] <= t[0];
      wr(OFS_OTYPE, {31'h0, t[1]});
      idle(4);
      chk({pin_oe[0], pin_out[0]}, t[1] ? {!t[0], 1'b0} : {1'b1, t[0]});
      chk(periph[15:0], {12'h0, t[0], 3'h0});
    end
    wr(OFS_AFR, 32'h0);
    wr(OFS_OTYPE, 32'h0);
    wr(OFS_ODR, 32'hFF);
    for (int t = 0; t < 5; t++)
    begin
      osc <= (t == 0) ? 6'h01 : (t == 1) ? 6'h03 : (t == 2) ? 6'h04 : (t == 3) ? 6'h08 : 6'h18;
      idle(4);
      case (t)
        0: chk({pin_oe, ibe}, 16'hF9F9);
        1: chk(pin_oe, 8'hFD);
        2: chk(pin_oe, 8'hF9);
        3: chk(pin_oe, 8'hCF);
        default: chk(pin_oe, 8'hDF);
      endcase
    end
    osc <= 6'h0;
    ext_en <= 8'hFF;
    wr(OFS_DIR, 32'h0);
    wr(OFS_INTEN, 32'hFF);
    for (int m = 0; m < 4; m++)
    begin
      ext_val <= {8{!m[0]}};
      wr(OFS_INTTYP, {24'h0, {8{m[1]}}});
      wr(OFS_INTPOL, {24'h0, {8{m[0]}}});
      idle(4);
      wr(OFS_INTCLR, 32'hFF);
      idle(2);
      rchk(OFS_RAWST, 32'h0);
      sleep <= (m == 2);
      ext_val[0] <= m[0];
      idle(4);
      rchk(OFS_RAWST, 32'h1);
      rchk(OFS_MSKST, 32'h1);
      chk({irq, wake}, {1'b1, m == 2});
      wr(OFS_INTCLR, 32'h1);
      idle(2);
      rchk(OFS_RAWST, {31'h0, !m[1]});
      sleep <= 1'b0;
      idle(2);
      chk(wake, 1'b0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
